// *** ctimer_pkg.sv ***
package ctimer_pkg;
   // counter geometry
   localparam int          CNT_W      = 16;
   localparam logic [15:0] CNT_ZERO   = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] CNT_ONE    = 16'h0001;
   localparam logic [15:0] CNT_RESET  = 16'h0000;
   // sync/trigger source vector, entry 0 means no source
   localparam int          SRC_W      = 32;
   localparam logic [4:0]  SYNC_NONE  = 5'h00;
   // timer clock tick sources
   localparam int          TICK_W     = 8;
   // capture mode field encodings
   localparam logic [2:0]  MODE_OFF     = 3'h0;
   localparam logic [2:0]  MODE_BOTH    = 3'h1;
   localparam logic [2:0]  MODE_FALL    = 3'h2;
   localparam logic [2:0]  MODE_RISE    = 3'h3;
   localparam logic [2:0]  MODE_RISE4   = 3'h4;
   localparam logic [2:0]  MODE_RISE16  = 3'h5;
   localparam logic [2:0]  MODE_DISABLE = 3'h6;
   localparam logic [2:0]  MODE_WAKE    = 3'h7;
   // prescaler terminal counts
   localparam logic [3:0]  PRESC_ZERO = 4'h0;
   localparam logic [3:0]  PRESC_ONE  = 4'h1;
   localparam logic [3:0]  PRESC_4    = 4'h3;
   localparam logic [3:0]  PRESC_16   = 4'hF;
   // captures per interrupt counter
   localparam logic [1:0]  IRQ_ZERO   = 2'h0;
   localparam logic [1:0]  IRQ_ONE    = 2'h1;
   // reset values of status
   localparam logic        TRIG_RESET = 1'b0;
   localparam logic        CASC_RESET = 1'b0;
   // timer operating mode, one-hot
   typedef enum logic [2:0] {
      TM_FREE = 3'b001,
      TM_SYNC = 3'b010,
      TM_TRIG = 3'b100
   } timer_mode_type;
endpackage : ctimer_pkg

// *** ctimer_link_if.sv ***
`timescale 1ns/1ps
interface ctimer_link_if;
   import ctimer_pkg::*;
   logic [SRC_W-1:0] sync_src;    // sync/trigger lines from neighbours
   logic             cascade_in;  // carry from the odd partner
   logic             cascade_out; // carry to the even partner
   modport dev (
      input  sync_src,
      input  cascade_in,
      output cascade_out
   );
   modport nbr (
      output sync_src,
      output cascade_in,
      input  cascade_out
   );
endinterface : ctimer_link_if

// *** ctimer_pin_edge.sv ***
`timescale 1ns/1ps
module ctimer_pin_edge (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_pin,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta_r;
   logic sync_r;
   logic last_r;

   // two-stage synchroniser, first stage read only by second
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= i_pin;
         sync_r <= meta_r;
      end
   end

   // delayed copy for edge detection
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         last_r <= 1'b0;
      end else begin
         last_r <= sync_r;
      end
   end

   assign o_rise = sync_r & ~last_r;
   assign o_fall = ~sync_r & last_r;
endmodule : ctimer_pin_edge

// *** ctimer_channel.sv ***
`timescale 1ns/1ps
// What this block does
// - wake mode plus irq enable wakes on capture
// - wake mode bypasses prescaler, ignores per-irq count
// - doze behaves exactly like normal run
// - module disable ignores writes, reads zero
// - 16-bit up-counter wrapping after FFFFh
// - no trigger, source set: synchronous, status ignored
// - sync mode counts on selected timer clock
// - sync input high clears and holds counter
// - neighbours share clock, sync source enabled last
// - trigger edge or software sets status; software clears
// - status zero holds counter, one lets it count
// - clearing status resets counter and rearms
// - waiting counter still captures value zero
// - trigger taken on rising edge only
// - trigger driver synchronous, pulses one cycle minimum
// - software configures fully before enabling mode
// - cascade pair forms 32 bits, odd low
// - cascade counter counts only while carry high
// - odd at FFFFh raises carry for even
// - cascade, trigger, source zero pick eight configs
module ctimer_channel
   import ctimer_pkg::*;
(
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_capture_pin,
   input  wire logic [2:0]            i_capture_mode_field,
   input  wire logic                  i_channel_irq_enable,
   input  wire logic [1:0]            i_captures_per_irq_field,
   input  wire logic                  i_module_disable_bit,
   input  wire logic                  i_trigger_mode_bit,
   input  wire logic [4:0]            i_sync_source_field,
   input  wire logic                  i_cascade_enable_bit,
   input  wire logic [2:0]            i_timer_clock_select,
   input  wire logic [TICK_W-1:0]     i_tick_src,
   input  wire logic                  i_trig_sw_set,
   input  wire logic                  i_trig_sw_clear,
   ctimer_link_if.dev                 link,
   output logic      [CNT_W-1:0]      o_timer_value,
   output logic                       o_trigger_status_bit,
   output logic      [CNT_W-1:0]      o_capture_value,
   output logic                       o_capture_strobe,
   output logic                       o_capture_irq,
   output logic                       o_wake
);
   logic             live;
   logic             tick;
   logic             sel_in;
   logic             sel_last_r;
   logic             trig_rise;
   logic             mode_on;
   logic             src_set;
   timer_mode_type   tmode;
   logic             trig_r;
   logic             trig_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic             inc_ok;
   logic             casc_r;
   logic             pin_rise;
   logic             pin_fall;
   logic [3:0]       presc_r;
   logic             cap_evt;
   logic [1:0]       irq_cnt_r;
   logic             irq_each;

   // a disabled module holds counter, status, carry and prescaler; pin sync, strobe, irq and wake registers keep clocking
   assign live    = ~i_module_disable_bit;
   assign mode_on = (i_capture_mode_field != MODE_OFF);
   assign src_set = (i_sync_source_field != SYNC_NONE);
   // doze only slows the cpu; nothing here looks at it
   assign tick    = i_tick_src[i_timer_clock_select];
   assign sel_in  = link.sync_src[i_sync_source_field];

   // selected source is already synchronous, so only a delay for the edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sel_last_r <= 1'b0;
      end else if (live) begin
         sel_last_r <= sel_in;
      end
   end
   assign trig_rise = sel_in & ~sel_last_r;

   // configuration decode, cascade is an orthogonal gate below
   always_comb begin
      if (i_trigger_mode_bit) begin
         tmode = TM_TRIG;
      end else if (src_set) begin
         tmode = TM_SYNC;
      end else begin
         tmode = TM_FREE;
      end
   end

   // trigger status: set beats clear so a simultaneous trigger is kept
   always_comb begin
      trig_nxt = trig_r;
      if (live) begin
         if ((tmode == TM_TRIG && src_set && trig_rise) || i_trig_sw_set) begin
            trig_nxt = 1'b1;
         end else if (i_trig_sw_clear) begin
            trig_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         trig_r <= TRIG_RESET;
      end else begin
         trig_r <= trig_nxt;
      end
   end

   // counter increments only with carry present when cascaded
   assign inc_ok = tick & (~i_cascade_enable_bit | link.cascade_in);

   always_comb begin
      cnt_nxt = cnt_r;
      if (live) begin
         if (!mode_on) begin
            cnt_nxt = CNT_ZERO;
         end else begin
            unique case (tmode)
               TM_FREE: begin
                  if (inc_ok) begin
                     cnt_nxt = cnt_r + CNT_ONE;
                  end
               end
               TM_SYNC: begin
                  if (tick && sel_in) begin
                     cnt_nxt = CNT_ZERO;
                  end else if (inc_ok) begin
                     cnt_nxt = cnt_r + CNT_ONE;
                  end
               end
               TM_TRIG: begin
                  if (!trig_nxt) begin
                     cnt_nxt = CNT_ZERO;
                  end else if (inc_ok) begin
                     cnt_nxt = cnt_r + CNT_ONE;
                  end
               end
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   // carry stands while the low half sits at its top value
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         casc_r <= CASC_RESET;
      end else if (live) begin
         casc_r <= i_cascade_enable_bit && (cnt_nxt == CNT_MAX);
      end
   end
   assign link.cascade_out = casc_r;

   // reads of a disabled module return zero
   assign o_timer_value        = cnt_r & {CNT_W{live}};
   assign o_trigger_status_bit = trig_r & live;

   ctimer_pin_edge u_pin_edge (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_pin   (i_capture_pin),
      .o_rise  (pin_rise),
      .o_fall  (pin_fall)
   );

   // prescaler runs only in the divided modes, idle otherwise
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         presc_r <= PRESC_ZERO;
      end else if (live) begin
         if (i_capture_mode_field != MODE_RISE4 && i_capture_mode_field != MODE_RISE16) begin
            presc_r <= PRESC_ZERO;
         end else if (pin_rise) begin
            presc_r <= presc_r + PRESC_ONE;
         end
      end
   end

   // capture event selection per mode
   always_comb begin
      cap_evt = 1'b0;
      if (live) begin
         unique case (i_capture_mode_field)
            MODE_BOTH:    cap_evt = pin_rise | pin_fall;
            MODE_FALL:    cap_evt = pin_fall;
            MODE_RISE:    cap_evt = pin_rise;
            MODE_RISE4:   cap_evt = pin_rise && (presc_r[1:0] == PRESC_4[1:0]);
            MODE_RISE16:  cap_evt = pin_rise && (presc_r == PRESC_16);
            MODE_WAKE:    cap_evt = pin_rise;
            MODE_OFF,
            MODE_DISABLE: cap_evt = 1'b0;
         endcase
      end
   end

   // a waiting triggered timer reads zero, so zero is captured
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_capture_value  <= CNT_ZERO;
         o_capture_strobe <= 1'b0;
      end else begin
         o_capture_strobe <= cap_evt;
         if (cap_evt) begin
            o_capture_value <= cnt_r;
         end
      end
   end

   // wake and both-edge modes interrupt on every capture
   assign irq_each = (i_capture_mode_field == MODE_WAKE)
                   || (i_capture_mode_field == MODE_BOTH)
                   || (i_captures_per_irq_field == IRQ_ZERO);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_cnt_r     <= IRQ_ZERO;
         o_capture_irq <= 1'b0;
      end else begin
         o_capture_irq <= 1'b0;
         if (!mode_on) begin
            irq_cnt_r <= IRQ_ZERO;
         end else if (cap_evt) begin
            if (irq_each || irq_cnt_r == i_captures_per_irq_field) begin
               irq_cnt_r     <= IRQ_ZERO;
               o_capture_irq <= 1'b1;
            end else begin
               irq_cnt_r <= irq_cnt_r + IRQ_ONE;
            end
         end
      end
   end

   // wake request does not depend on the timer running
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= live && (i_capture_mode_field == MODE_WAKE)
                   && i_channel_irq_enable && pin_rise;
      end
   end
endmodule : ctimer_channel

// *** ctimer_neighbour.sv ***
`timescale 1ns/1ps
module ctimer_neighbour
   import ctimer_pkg::*;
(
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [SRC_W-1:0] i_sync_level,
   input  wire logic             i_carry_level,
   ctimer_link_if.nbr            link,
   output logic                  o_carry_seen
);
   logic [SRC_W-1:0] sync_r;
   logic             carry_r;

   // registered on the shared clock, so every line is synchronous
   // and any request lasts at least one whole cycle
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_r  <= {SRC_W{1'b0}};
         carry_r <= 1'b0;
      end else begin
         sync_r  <= i_sync_level;
         carry_r <= i_carry_level;
      end
   end

   // entry 0 is the no-source slot and stays low
   assign link.sync_src   = {sync_r[SRC_W-1:1], 1'b0};
   assign link.cascade_in = carry_r;

   // carry back from the channel, same clock, no synchroniser
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_carry_seen <= 1'b0;
      end else begin
         o_carry_seen <= link.cascade_out;
      end
   end
endmodule : ctimer_neighbour

// *** ctimer_properties.sv ***
`timescale 1ns/1ps
module ctimer_properties
   import ctimer_pkg::*;
(
   input wire logic              i_clk,
   input wire logic              i_rst_n,
   input wire logic [SRC_W-1:0]  sync_src,
   input wire logic              cascade_in,
   input wire logic              cascade_out,
   input wire logic [CNT_W-1:0]  o_timer_value,
   input wire logic              o_trigger_status_bit,
   input wire logic [2:0]        i_capture_mode_field,
   input wire logic              i_module_disable_bit,
   input wire logic              i_trigger_mode_bit,
   input wire logic [4:0]        i_sync_source_field,
   input wire logic              i_cascade_enable_bit,
   input wire logic [2:0]        i_timer_clock_select,
   input wire logic [TICK_W-1:0] i_tick_src
);
   logic tick;
   logic sel;
   logic run;
   logic plain;
   logic dis;
   // decode of selected tick and sync line; plain = neither trigger nor sync clear
   assign tick  = i_tick_src[i_timer_clock_select];
   assign sel   = sync_src[i_sync_source_field];
   assign dis   = i_module_disable_bit;
   assign run   = (i_capture_mode_field != MODE_OFF) && !dis;
   assign plain = !i_trigger_mode_bit && !(sel && i_sync_source_field != SYNC_NONE);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   a_reset_clears_all: assert property ($rose(i_rst_n) |->
      o_timer_value == CNT_ZERO && !o_trigger_status_bit && !cascade_out) else $error("reset");
   a_disabled_reads_zero: assert property (dis |->
      o_timer_value == CNT_ZERO && !o_trigger_status_bit) else $error("disabled read");
   a_tick_increments: assert property (plain && run && tick &&
      (!i_cascade_enable_bit || cascade_in) ##1 !dis |->
      o_timer_value == $past(o_timer_value) + CNT_ONE) else $error("no increment");
   a_idle_holds_count: assert property (plain && run &&
      (!tick || (i_cascade_enable_bit && !cascade_in)) ##1 !dis |->
      $stable(o_timer_value)) else $error("count moved");
   a_sync_clears_count: assert property (!i_trigger_mode_bit &&
      i_sync_source_field != SYNC_NONE && sel && run && tick ##1 !dis |->
      o_timer_value == CNT_ZERO) else $error("sync clear");
   a_trig_wait_zero: assert property (i_trigger_mode_bit && run &&
      !o_trigger_status_bit ##1 !o_trigger_status_bit && !dis |->
      o_timer_value == CNT_ZERO) else $error("held count");
   a_trig_edge_sets: assert property (i_trigger_mode_bit &&
      i_sync_source_field != SYNC_NONE && $stable(i_sync_source_field) && $rose(sel)
      && !dis ##1 !dis |-> o_trigger_status_bit) else $error("trigger missed");
   a_carry_at_max: assert property (i_cascade_enable_bit &&
      $stable(i_cascade_enable_bit) && $stable(dis) && !dis |->
      cascade_out == (o_timer_value == CNT_MAX)) else $error("carry out");
   // main scenarios reached
   c_carry_wrap: cover property (cascade_out ##1 o_timer_value == CNT_ZERO);
   c_trig_set: cover property ($rose(o_trigger_status_bit));
   c_sync_hold: cover property (sel && !i_trigger_mode_bit && i_sync_source_field != 5'h00);
endmodule : ctimer_properties

// *** tb_capture_dedicated_timer.sv ***
`timescale 1ns/1ps
module tb_capture_dedicated_timer;
   import ctimer_pkg::*;
   logic              i_clk   = 1'b0;
   logic              i_rst_n = 1'b0;
   logic              pin     = 1'b0;
   logic              irq_en  = 1'b0;
   logic              dis     = 1'b0;
   logic              trig    = 1'b0;
   logic              casc    = 1'b0;
   logic              sw_set  = 1'b0;
   logic              sw_clr  = 1'b0;
   logic              carry   = 1'b0;
   logic [2:0]        mode    = 3'h0;
   logic [1:0]        per_irq = 2'h3;
   logic [4:0]        src     = 5'h00;
   logic [2:0]        csel    = 3'h0;
   logic [TICK_W-1:0] tick    = 8'hFF;
   logic [SRC_W-1:0]  lvl     = 32'h0;
   logic [CNT_W-1:0]  tv, cap_v, cv, v, ns, nw;
   logic              st, cap_stb, cap_irq, cap_wake, seen, got, wk, iq;
   int                n_mismatch = 0;
   int                checked = 0;
   // free clock, 10 ns period
   always #5 i_clk = ~i_clk;
   ctimer_link_if u_ctimer_link_if ();
   ctimer_channel u_ctimer_channel (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_capture_pin(pin),
      .i_capture_mode_field(mode), .i_channel_irq_enable(irq_en),
      .i_captures_per_irq_field(per_irq), .i_module_disable_bit(dis),
      .i_trigger_mode_bit(trig), .i_sync_source_field(src), .i_cascade_enable_bit(casc),
      .i_timer_clock_select(csel), .i_tick_src(tick), .i_trig_sw_set(sw_set),
      .i_trig_sw_clear(sw_clr), .link(u_ctimer_link_if), .o_timer_value(tv),
      .o_trigger_status_bit(st), .o_capture_value(cap_v), .o_capture_strobe(cap_stb),
      .o_capture_irq(cap_irq), .o_wake(cap_wake));
   ctimer_neighbour u_ctimer_neighbour (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_sync_level(lvl), .i_carry_level(carry), .link(u_ctimer_link_if),
      .o_carry_seen(seen));
   ctimer_properties u_ctimer_properties (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .sync_src(u_ctimer_link_if.sync_src), .cascade_in(u_ctimer_link_if.cascade_in),
      .cascade_out(u_ctimer_link_if.cascade_out), .o_timer_value(tv),
      .o_trigger_status_bit(st), .i_capture_mode_field(mode), .i_module_disable_bit(dis),
      .i_trigger_mode_bit(trig), .i_sync_source_field(src), .i_cascade_enable_bit(casc),
      .i_timer_clock_select(csel), .i_tick_src(tick));
   task automatic cmp(input logic [CNT_W-1:0] g, input logic [CNT_W-1:0] e);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp
   task automatic step(input int n);
      repeat (n) @(negedge i_clk);
   endtask : step
   // one software pulse: 1 sets the status bit, 0 clears it
   // a quiet edge follows so back-to-back pulses never retoggle in one step
   task automatic sw(input logic s);
      sw_set = s;
      sw_clr = !s;
      step(1);
      sw_set = 1'b0;
      sw_clr = 1'b0;
      step(1);
   endtask : sw
   // pin rise; strobe lasts one cycle so every negedge is looked at
   task automatic rise_pin();
      got = 1'b0;
      wk = 1'b0;
      iq = 1'b0;
      pin = 1'b1;
      for (int i = 0; i < 10; i++) begin
         step(1);
         if (cap_stb === 1'b1) begin
            got = 1'b1;
            cv = cap_v;
            wk = cap_wake;
            iq = cap_irq;
         end
      end
      pin = 1'b0;
      step(6);
      cmp(got, 1'b1);
   endtask : rise_pin
   // one pin pulse, eight cycles high then eight low; counts strobes and wakes
   task automatic pulse_pin(output logic [CNT_W-1:0] s_cnt, output logic [CNT_W-1:0] w_cnt);
      s_cnt = CNT_ZERO;
      w_cnt = CNT_ZERO;
      pin = 1'b1;
      for (int i = 0; i < 16; i++) begin
         if (i == 8) begin
            pin = 1'b0;
         end
         step(1);
         if (cap_stb === 1'b1) begin
            s_cnt = s_cnt + CNT_ONE;
         end
         if (cap_wake === 1'b1) begin
            w_cnt = w_cnt + CNT_ONE;
         end
      end
   endtask : pulse_pin
   task automatic t_free();
      csel = 3'h3;
      step(1);
      mode = MODE_RISE;
      // only ticks on the selected source may count
      for (int i = 0; i < 8; i++) begin
         tick = i[0] ? 8'h08 : 8'hF7;
         step(1);
      end
      tick = 8'hF7;
      step(2);
      cmp(tv, 16'h0004);
      csel = 3'h0;
      tick = 8'hFF;
      step(1);
      v = tv;
      step(1);
      cmp(tv, v + CNT_ONE);
      $display("test free done");
   endtask : t_free
   task automatic t_sync();
      src = 5'h04;
      lvl = 32'h10;
      sw(1'b1);
      step(3);
      cmp(tv, CNT_ZERO);
      step(2);
      cmp(tv, CNT_ZERO);
      lvl = 32'h0;
      step(3);
      v = tv;
      step(1);
      cmp(tv, v + CNT_ONE);
      $display("test sync done");
   endtask : t_sync
   task automatic t_trig();
      trig = 1'b1;
      sw(1'b0);
      step(2);
      cmp(tv, CNT_ZERO);
      rise_pin();
      cmp(cv, CNT_ZERO);
      lvl = 32'h10;
      step(3);
      cmp(st, 1'b1);
      v = tv;
      step(1);
      cmp(tv, v + CNT_ONE);
      sw(1'b0);
      step(4);
      cmp(st, 1'b0);
      cmp(tv, CNT_ZERO);
      lvl = 32'h0;
      step(2);
      lvl = 32'h10;
      step(3);
      cmp(st, 1'b1);
      src = SYNC_NONE;
      lvl = 32'h0;
      sw(1'b0);
      sw(1'b1);
      step(1);
      v = tv;
      step(1);
      cmp(tv, v + CNT_ONE);
      trig = 1'b0;
      sw(1'b0);
      $display("test trigger done");
   endtask : t_trig
   task automatic t_wake();
      tick = 8'h00;
      mode = MODE_WAKE;
      irq_en = 1'b1;
      rise_pin();
      cmp(wk, 1'b1);
      rise_pin();
      cmp(iq, 1'b1);
      irq_en = 1'b0;
      rise_pin();
      cmp(wk, 1'b0);
      tick = 8'hFF;
      mode = MODE_RISE;
      $display("test wake done");
   endtask : t_wake
   task automatic t_disable();
      v = tv;
      dis = 1'b1;
      step(1);
      cmp(tv, CNT_ZERO);
      sw(1'b1);
      dis = 1'b0;
      step(1);
      cmp(st, 1'b0);
      cmp(tv, v + CNT_ONE);
      $display("test disable done");
   endtask : t_disable
   // edge modes and prescaled modes; wake must stay quiet outside wake mode
   task automatic t_modes();
      irq_en = 1'b1;
      mode = MODE_BOTH;
      pulse_pin(ns, nw);
      cmp(ns, 16'h0002);
      cmp(nw, CNT_ZERO);
      mode = MODE_FALL;
      pulse_pin(ns, nw);
      cmp(ns, CNT_ONE);
      cmp(nw, CNT_ZERO);
      mode = MODE_DISABLE;
      pulse_pin(ns, nw);
      cmp(ns, CNT_ZERO);
      mode = MODE_RISE4;
      for (int i = 0; i < 3; i++) begin
         pulse_pin(ns, nw);
         cmp(ns, CNT_ZERO);
      end
      pulse_pin(ns, nw);
      cmp(ns, CNT_ONE);
      // a plain mode between clears the prescaler left by the last one
      mode = MODE_RISE;
      step(1);
      mode = MODE_RISE16;
      for (int i = 0; i < 15; i++) begin
         pulse_pin(ns, nw);
         cmp(ns, CNT_ZERO);
      end
      pulse_pin(ns, nw);
      cmp(ns, CNT_ONE);
      cmp(nw, CNT_ZERO);
      irq_en = 1'b0;
      mode = MODE_RISE;
      $display("test modes done");
   endtask : t_modes
   // mid-run reset with the count running and the status bit set
   task automatic t_reset();
      trig = 1'b1;
      sw(1'b1);
      cmp(st, 1'b1);
      i_rst_n = 1'b0;
      step(1);
      cmp(tv, CNT_RESET);
      cmp(st, TRIG_RESET);
      trig = 1'b0;
      i_rst_n = 1'b1;
      step(1);
      cmp(tv, CNT_ONE);
      cmp(st, TRIG_RESET);
      $display("test reset done");
   endtask : t_reset
   task automatic t_cascade();
      mode = MODE_OFF;
      casc = 1'b1;
      step(2);
      mode = MODE_RISE;
      step(3);
      cmp(tv, CNT_ZERO);
      carry = 1'b1;
      for (int i = 0; i < 70000 && tv !== CNT_MAX; i++) step(1);
      cmp(u_ctimer_link_if.cascade_out, 1'b1);
      step(1);
      cmp(tv, CNT_ZERO);
      cmp(seen, 1'b1);
      $display("test cascade done");
   endtask : t_cascade
   task automatic end_sim();
      $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   // main sequence; config settles before the mode leaves off
   initial begin
      step(2);
      i_rst_n = 1'b1;
      step(1);
      cmp(tv, CNT_RESET);
      cmp(st, TRIG_RESET);
      t_free();
      t_sync();
      t_trig();
      t_wake();
      t_modes();
      t_disable();
      t_reset();
      t_cascade();
      end_sim();
   end
   // watchdog: the cascade wrap needs about 66k cycles, all else about five hundred
   initial begin
      #900000;
      n_mismatch++;
      end_sim();
   end
endmodule : tb_capture_dedicated_timer
